//--- spotp_pkg.sv
// Shared constants, types and field layout of the pixel serializer
// Functional notes
// - Each 14-bit pixel word sits inside a 16-slot (dual) or 8-slot (quad) serial frame with guards.
// - Output supports selectable dual-lane and quad-lane arrangements.
// - Frame marker rises with the launch of the word's most significant bit.
// - In double sampling mode pixels alternate even and odd sampling paths.
// - Double sampling odd pixels hold the marker high three clock periods in quad-lane, six in dual-lane.
// - Double sampling even pixels hold the marker high two clock periods in quad-lane, four in dual-lane.
// - Sample-and-hold pixels all get the odd-pixel marker pulse, three periods quad, six dual.
// - Dual-lane gives each channel one lane at sixteen slots per pixel.
// - Dual-lane marker falls at bit 7, or alternately bit 9 and 7.
// - Dual-lane forwarded clock changes at the centre of each bit.
// - Quad-lane splits each channel, bits 13..7 and 6..0, eight slots.
// - Quad-lane marker falls at bits 10/3 for odd, 11/4 for even.
// - Quad-lane forwarded clock changes inside each data bit.
// - Global power-down bit stops all analog blocks and overrides others.
// - Six per-block power-down bits allow single-channel operation.
// - Amplifier and converter trim registers apply to both channels.
// - Three-bit select picks fixed, gradients, lattice, stripe, fixed words.
// - Enabled pattern runs without end in place of converter data.
// - Pattern starts with zero-code start period, then valid-pixel region.
// - Pattern output begins at the next clamp line pulse leading edge, except the async word pattern.
// - Fixed code joins upper 6 bits and lower 8 bits from two registers.
`default_nettype none
package spotp_pkg;
  localparam int PIX_W = 14;
  localparam int FIFO_DEPTH = 8;
  // Register offsets
  localparam logic [5:0] REG_PWR_DOWN = 6'h01;
  localparam logic [5:0] REG_AMP_TRIM = 6'h02;
  localparam logic [5:0] REG_CONV_TRIM = 6'h03;
  localparam logic [5:0] REG_PAT_CTRL = 6'h34;
  localparam logic [5:0] REG_PAT_START = 6'h35;
  localparam logic [5:0] REG_PAT_WIDTH = 6'h36;
  localparam logic [5:0] REG_PAT_VAL_HI = 6'h37;
  localparam logic [5:0] REG_PAT_VAL_LO = 6'h38;
  localparam logic [5:0] REG_TEST_SCAN = 6'h3d;
  localparam logic [5:0] REG_OUT_FMT = 6'h3e;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int PD_GLOBAL_BIT = 7;
  localparam int PD_CLAMP_BIT = 6;
  localparam int PAT_EN_BIT = 0;
  localparam int PAT_SEL_LSB = 4;
  localparam int TEST_MODE_BIT = 1;
  localparam int FMT_QUAD_BIT = 0;
  localparam int FMT_DSAMP_BIT = 1;
  // Slot timing, in bit slots of the serial frame
  localparam logic [3:0] DUAL_LAST = 4'hf;
  localparam logic [3:0] QUAD_LAST = 4'h7;
  localparam logic [3:0] MSB_SLOT = 4'h1;
  localparam logic [3:0] DUAL_DATA_END = 4'he;
  localparam logic [3:0] DUAL_FALL_ODD = 4'h7;
  localparam logic [3:0] DUAL_FALL_EVEN = 4'h5;
  localparam logic [3:0] QUAD_FALL_ODD = 4'h4;
  localparam logic [3:0] QUAD_FALL_EVEN = 4'h3;
  localparam logic [3:0] LSB_LANE_TOP = 4'h7;
  localparam logic [3:0] MSB_LANE_TOP = 4'he;

  typedef enum logic [2:0] {
    PAT_FIXED = 3'b000,
    PAT_HGRAD = 3'b001,
    PAT_VGRAD = 3'b010,
    PAT_LATTICE = 3'b011,
    PAT_STRIPE = 3'b100,
    PAT_SYNC_WORD = 3'b101,
    PAT_ASYNC_WORD = 3'b110,
    PAT_RESERVED = 3'b111
  } spotp_pat_e;

  typedef struct packed {
    logic odd;
    logic [PIX_W-1:0] ch2;
    logic [PIX_W-1:0] ch1;
  } spotp_pixel_s;

  typedef struct packed {
    logic clamp_ref;
    logic [1:0] ref_buf;
    logic [1:0] gain_amp;
    logic [1:0] input_amp;
  } spotp_power_s;
endpackage
`default_nettype wire

//--- spotp_top.sv
// Pixel FIFO and the serial pixel output block with pattern generator
`default_nettype none
module spotp_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,   // Block clock
  input  wire logic             reset,     // Synchronous, active high
  input  wire logic [WIDTH-1:0] in_data,   // Word to store
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Space left
  output logic      [WIDTH-1:0] out_data,  // Oldest word
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready  // Drain accepts
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Handshakes are combinational on the count
  assign in_ready  = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  // Storage entries
  genvar gi;
  for (gi = 0; gi < DEPTH; gi++) begin : g_ent
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        mem_q[gi] <= '0;
      end else if (push && (wr_q == AW'(gi))) begin
        mem_q[gi] <= in_data;
      end
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_IDX) ? '0 : AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_IDX) ? '0 : AW'(rd_q + 1'b1);
      end
    end
  end

  // Occupancy
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_q <= (AW+1)'(cnt_q - 1'b1);
    end
  end
endmodule

module spotp_top
  import spotp_pkg::*;
(
  input  wire logic             ref_clk,             // Bit clock, 40 MHz
  input  wire logic             reset,               // Sync, active high
  input  wire logic             pixel_clk,           // Pixel input clock
  input  wire logic             clamp_line_pulse,    // Line clamp pin
  input  wire logic [PIX_W-1:0] conv_ch1,            // Converter channel 1
  input  wire logic [PIX_W-1:0] conv_ch2,            // Converter channel 2
  input  wire logic [5:0]       reg_addr,            // Register address
  input  wire logic [7:0]       reg_wdata,           // Register write data
  input  wire logic             reg_write,           // Write strobe
  output logic      [7:0]       reg_rdata,           // Read data
  output logic      [3:0]       serial_data_lane,    // Lane outputs
  output logic                  pixel_frame_marker,  // Word frame
  output logic                  forwarded_bit_clock, // Forwarded clock
  output logic                  pixel_ready,         // FIFO has room
  output spotp_power_s          power_down,          // Block power-downs
  output logic      [7:0]       amp_trim,            // Gain stage trim
  output logic      [7:0]       conv_trim            // Converter trim
);
  typedef enum logic [1:0] {
    PG_IDLE  = 2'b00,
    PG_ARMED = 2'b01,
    PG_START = 2'b10,
    PG_VALID = 2'b11
  } spotp_pg_e;

  logic [7:0]   pd_q;
  logic [7:0]   amp_q;
  logic [7:0]   conv_q;
  logic [7:0]   pat_ctrl_q;
  logic [7:0]   pat_start_q;
  logic [7:0]   pat_width_q;
  logic [7:0]   val_hi_q;
  logic [7:0]   val_lo_q;
  logic [7:0]   scan_q;
  logic [7:0]   fmt_q;
  logic [7:0]   rdata_d;
  logic [2:0]   pclk_sync_q;
  logic [2:0]   clamp_sync_q;
  logic         pix_edge;
  logic         clamp_rise;
  logic         clamp_seen_q;
  spotp_pg_e    pg_q;
  logic [7:0]   pg_cnt_q;
  logic         pat_on;
  logic         async_sel;
  spotp_pat_e   pat_sel;
  logic [PIX_W-1:0] pat_word;
  logic [PIX_W-1:0] fixed_word;
  logic         odd_q;
  logic         quad;
  logic         correlated_double_sampling_mode;
  spotp_pixel_s cap_d;
  spotp_pixel_s cap_q;
  logic         cap_valid_q;
  spotp_pixel_s fifo_out;
  logic         fifo_valid;
  logic         slot_wrap;
  logic [3:0]   slot_q;
  logic [3:0]   last_slot;
  spotp_pixel_s word_q;
  logic         word_valid_q;
  logic [3:0]   msb_idx;
  logic [3:0]   lsb_idx;
  logic [3:0]   fall_slot;
  logic         in_msb_lane;
  logic         in_dual_data;
  logic [3:0]   lane_d;
  logic         frame_d;

  assign quad = fmt_q[FMT_QUAD_BIT];
  assign correlated_double_sampling_mode = fmt_q[FMT_DSAMP_BIT];

  // Register writes; every register resets to zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pd_q        <= REG_RESET;
      amp_q       <= REG_RESET;
      conv_q      <= REG_RESET;
      pat_ctrl_q  <= REG_RESET;
      pat_start_q <= REG_RESET;
      pat_width_q <= REG_RESET;
      val_hi_q    <= REG_RESET;
      val_lo_q    <= REG_RESET;
      scan_q      <= REG_RESET;
      fmt_q       <= REG_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        REG_PWR_DOWN:   pd_q        <= reg_wdata;
        REG_AMP_TRIM:   amp_q       <= reg_wdata;
        REG_CONV_TRIM:  conv_q      <= reg_wdata;
        REG_PAT_CTRL:   pat_ctrl_q  <= reg_wdata;
        REG_PAT_START:  pat_start_q <= reg_wdata;
        REG_PAT_WIDTH:  pat_width_q <= reg_wdata;
        REG_PAT_VAL_HI: val_hi_q    <= reg_wdata;
        REG_PAT_VAL_LO: val_lo_q    <= reg_wdata;
        REG_TEST_SCAN:  scan_q      <= reg_wdata;
        REG_OUT_FMT:    fmt_q       <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      REG_PWR_DOWN:   rdata_d = pd_q;
      REG_AMP_TRIM:   rdata_d = amp_q;
      REG_CONV_TRIM:  rdata_d = conv_q;
      REG_PAT_CTRL:   rdata_d = pat_ctrl_q;
      REG_PAT_START:  rdata_d = pat_start_q;
      REG_PAT_WIDTH:  rdata_d = pat_width_q;
      REG_PAT_VAL_HI: rdata_d = val_hi_q;
      REG_PAT_VAL_LO: rdata_d = val_lo_q;
      REG_TEST_SCAN:  rdata_d = scan_q;
      REG_OUT_FMT:    rdata_d = {5'h00, pg_q != PG_IDLE, fmt_q[1:0]};
      default:        rdata_d = 8'h00;
    endcase
  end

  // Registered read data, one cycle after the address
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // Power controls; global bit overrides each per-block bit
  always_comb begin
    power_down.clamp_ref = pd_q[PD_GLOBAL_BIT] | pd_q[PD_CLAMP_BIT];
    power_down.input_amp = pd_q[PD_GLOBAL_BIT] ? 2'b11 : {pd_q[3], pd_q[0]};
    power_down.gain_amp  = pd_q[PD_GLOBAL_BIT] ? 2'b11 : {pd_q[4], pd_q[1]};
    power_down.ref_buf   = pd_q[PD_GLOBAL_BIT] ? 2'b11 : {pd_q[5], pd_q[2]};
  end

  // One trim setting drives both channels alike
  assign amp_trim  = amp_q;
  assign conv_trim = conv_q;

  // Pin synchronisers; only the second and third stages are looked at
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pclk_sync_q  <= 3'h0;
      clamp_sync_q <= 3'h0;
    end else begin
      pclk_sync_q  <= {pclk_sync_q[1:0], pixel_clk};
      clamp_sync_q <= {clamp_sync_q[1:0], clamp_line_pulse};
    end
  end

  assign pix_edge   = pclk_sync_q[1] && !pclk_sync_q[2];
  assign clamp_rise = clamp_sync_q[1] && !clamp_sync_q[2];

  // Clamp edge is held until the next pixel edge consumes it; set wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clamp_seen_q <= 1'b0;
    end else if (clamp_rise) begin
      clamp_seen_q <= 1'b1;
    end else if (pix_edge) begin
      clamp_seen_q <= 1'b0;
    end
  end

  assign pat_on    = pat_ctrl_q[PAT_EN_BIT] && scan_q[TEST_MODE_BIT];
  assign pat_sel   = spotp_pat_e'(pat_ctrl_q[PAT_SEL_LSB +: 3]);
  assign async_sel = (pat_sel == PAT_ASYNC_WORD);

  // Pattern sequencer, advanced once per pixel; runs until disabled.
  // Parameters are sampled live, so edits while enabled give odd output.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pg_q     <= PG_IDLE;
      pg_cnt_q <= 8'h00;
    end else if (!pat_on) begin
      pg_q     <= PG_IDLE;
      pg_cnt_q <= 8'h00;
    end else if (pix_edge) begin
      case (pg_q)
        PG_IDLE: begin
          pg_q     <= async_sel ? PG_START : PG_ARMED;
          pg_cnt_q <= 8'h00;
        end
        PG_ARMED: begin
          if (clamp_seen_q || clamp_rise) begin
            pg_q     <= (pat_start_q == 8'h00) ? PG_VALID : PG_START;
            pg_cnt_q <= 8'h00;
          end
        end
        PG_START: begin
          if (8'(pg_cnt_q + 1'b1) >= pat_start_q) begin
            pg_q     <= PG_VALID;
            pg_cnt_q <= 8'h00;
          end else begin
            pg_cnt_q <= 8'(pg_cnt_q + 1'b1);
          end
        end
        PG_VALID: begin
          if (8'(pg_cnt_q + 1'b1) >= pat_width_q) begin
            pg_q     <= async_sel ? PG_START : PG_ARMED;
            pg_cnt_q <= 8'h00;
          end else begin
            pg_cnt_q <= 8'(pg_cnt_q + 1'b1);
          end
        end
        default: begin
          pg_q     <= PG_IDLE;
          pg_cnt_q <= 8'h00;
        end
      endcase
    end
  end

  assign fixed_word = {val_hi_q[5:0], val_lo_q};

  // Pattern word in the valid region; finer pattern shapes are simplified
  always_comb begin
    case (pat_sel)
      PAT_FIXED:      pat_word = fixed_word;
      PAT_HGRAD:      pat_word = PIX_W'(fixed_word + pg_cnt_q);
      PAT_VGRAD:      pat_word = fixed_word;
      PAT_LATTICE:    pat_word = fixed_word;
      PAT_STRIPE:     pat_word = fixed_word;
      PAT_SYNC_WORD:  pat_word = fixed_word;
      PAT_ASYNC_WORD: pat_word = fixed_word;
      default:        pat_word = '0;
    endcase
  end

  // Source select: zero code outside the valid region while enabled
  always_comb begin
    cap_d.odd = correlated_double_sampling_mode ? odd_q
                                                : 1'b1;
    if (pg_q == PG_IDLE) begin
      cap_d.ch1 = conv_ch1;
      cap_d.ch2 = conv_ch2;
    end else if (pg_q == PG_VALID) begin
      cap_d.ch1 = pat_word;
      cap_d.ch2 = pat_word;
    end else begin
      cap_d.ch1 = '0;
      cap_d.ch2 = '0;
    end
  end

  // Even/odd path alternates on every pixel of a channel
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      odd_q <= 1'b0;
    end else if (pix_edge) begin
      odd_q <= ~odd_q;
    end
  end

  // Capture one pixel pair per pixel clock edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cap_q       <= '0;
      cap_valid_q <= 1'b0;
    end else begin
      cap_valid_q <= pix_edge;
      if (pix_edge) begin
        cap_q <= cap_d;
      end
    end
  end

  // Pixel buffer; a full FIFO drops the offered pair and shows it
  spotp_fifo #(
    .WIDTH ($bits(spotp_pixel_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_data   (cap_q),
    .in_valid  (cap_valid_q),
    .in_ready  (pixel_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (slot_wrap)
  );

  assign last_slot = quad ? QUAD_LAST : DUAL_LAST;
  assign slot_wrap = (slot_q >= last_slot);

  // Slot counter; compare with >= so a format switch cannot run away
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      slot_q <= 4'h0;
    end else if (slot_wrap) begin
      slot_q <= 4'h0;
    end else begin
      slot_q <= 4'(slot_q + 1'b1);
    end
  end

  // Next word is loaded during the last slot, a guard slot in dual lane only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      word_q       <= '0;
      word_valid_q <= 1'b0;
    end else if (slot_wrap) begin
      word_q       <= fifo_out;
      word_valid_q <= fifo_valid;
    end
  end

  assign msb_idx      = 4'(MSB_LANE_TOP - slot_q);
  assign lsb_idx      = 4'(LSB_LANE_TOP - slot_q);
  assign in_msb_lane  = (slot_q >= MSB_SLOT) && (slot_q <= QUAD_LAST);
  assign in_dual_data = (slot_q >= MSB_SLOT) && (slot_q <= DUAL_DATA_END);

  // Lane bits, most significant first, zero in guard slots
  always_comb begin
    lane_d = 4'h0;
    if (!word_valid_q) begin
      lane_d = 4'h0;
    end else if (quad) begin
      if (in_msb_lane) begin
        lane_d[0] = word_q.ch1[msb_idx];
        lane_d[1] = word_q.ch1[lsb_idx];
        lane_d[2] = word_q.ch2[msb_idx];
        lane_d[3] = word_q.ch2[lsb_idx];
      end
    end else if (in_dual_data) begin
      lane_d[0] = word_q.ch1[msb_idx];
      lane_d[1] = word_q.ch2[msb_idx];
    end
  end

  // Marker falls earlier on even pixels to flag the sampling path
  always_comb begin
    if (quad) begin
      fall_slot = word_q.odd ? QUAD_FALL_ODD : QUAD_FALL_EVEN;
    end else begin
      fall_slot = word_q.odd ? DUAL_FALL_ODD : DUAL_FALL_EVEN;
    end
    frame_d = word_valid_q && (slot_q >= MSB_SLOT)
              && (slot_q < fall_slot);
  end

  // Registered lane and marker outputs share one launch edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_data_lane   <= 4'h0;
      pixel_frame_marker <= 1'b0;
    end else begin
      serial_data_lane   <= lane_d;
      pixel_frame_marker <= frame_d;
    end
  end

  // Forwarded clock changes once per bit; the output cell's half-bit
  // delay puts each change in the middle of the data eye
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      forwarded_bit_clock <= 1'b0;
    end else begin
      forwarded_bit_clock <= ~forwarded_bit_clock;
    end
  end
endmodule
`default_nettype wire

//--- spotp_properties.sv
// Concurrent checks on the serial pixel output ports
`default_nettype none
module spotp_checker
  import spotp_pkg::*;
(
  input wire logic         ref_clk,             // Bit clock
  input wire logic         reset,               // Sync reset
  input wire logic [5:0]   reg_addr,            // Address
  input wire logic [7:0]   reg_wdata,           // Write data
  input wire logic         reg_write,           // Write strobe
  input wire logic [7:0]   reg_rdata,           // Read data
  input wire logic [3:0]   serial_data_lane,    // Lanes
  input wire logic         pixel_frame_marker,  // Word frame
  input wire logic         forwarded_bit_clock, // Forwarded clock
  input wire spotp_power_s power_down,          // Power-downs
  input wire logic [7:0]   amp_trim,            // Gain trim
  input wire logic [7:0]   conv_trim            // Converter trim
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Register bits to power-down lines, channel 1 in bit 0 of each pair
  function automatic spotp_power_s pd_map(logic [7:0] w);
    return {w[6], w[5], w[2], w[4], w[1], w[3], w[0]};
  endfunction
  // One transition per bit slot keeps the receiver strobe centred
  a_clock_toggles: assert property (
    !reset |=> forwarded_bit_clock != $past(forwarded_bit_clock))
    else $error("forwarded clock missed a toggle");
  a_global_pd_wins: assert property (
    reg_write && reg_addr == REG_PWR_DOWN && reg_wdata[PD_GLOBAL_BIT]
    |=> power_down == 7'h7f)
    else $error("global power-down did not stop every block");
  a_single_chan_pd: assert property (
    reg_write && reg_addr == REG_PWR_DOWN && !reg_wdata[PD_GLOBAL_BIT]
    |=> power_down == pd_map($past(reg_wdata)))
    else $error("power-down bits mapped wrongly");
  a_amp_trim_write: assert property (
    reg_write && reg_addr == REG_AMP_TRIM |=> amp_trim == $past(reg_wdata))
    else $error("gain trim not written");
  a_conv_trim_write: assert property (
    reg_write && reg_addr == REG_CONV_TRIM
    |=> conv_trim == $past(reg_wdata))
    else $error("converter trim not written");
  a_guard_before_msb: assert property (
    $rose(pixel_frame_marker) |-> $past(serial_data_lane) == 4'h0)
    else $error("guard slot before the word was not zero");
  a_marker_width: assert property (
    $rose(pixel_frame_marker)
    |-> pixel_frame_marker[*2] ##[1:5] !pixel_frame_marker)
    else $error("frame marker pulse has a wrong width");
  a_marker_spacing: assert property (
    $rose(pixel_frame_marker) |=> (!$rose(pixel_frame_marker))[*7])
    else $error("frame markers closer than one quad frame");
endmodule
bind spotp_top spotp_checker spotp_checker_inst (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
  .serial_data_lane(serial_data_lane),
  .pixel_frame_marker(pixel_frame_marker),
  .forwarded_bit_clock(forwarded_bit_clock), .power_down(power_down),
  .amp_trim(amp_trim), .conv_trim(conv_trim));
`default_nettype wire

//--- spotp_rx_model.sv
// Behavioural deserializer at the far end of the serial lanes
`default_nettype none
module spotp_rx_model
  import spotp_pkg::*;
(
  input  wire logic             ref_clk,            // Bit clock
  input  wire logic [3:0]       serial_data_lane,   // Lanes from device
  input  wire logic             pixel_frame_marker, // Word frame
  input  wire logic             quad,               // Quad-lane layout
  output logic      [PIX_W-1:0] rx_ch1,             // Last ch1 word
  output logic      [PIX_W-1:0] rx_ch2,             // Last ch2 word
  output logic      [3:0]       rx_mlen,            // Marker high slots
  output int                    rx_cnt,             // Words captured
  output logic                  guard_bad           // Guard not zero
);
  logic [PIX_W-1:0] a1, b1, a2, b2;
  logic [3:0]       mlen, prev_l;
  logic             prev_m;
  int               pos;
  initial begin
    rx_cnt = 0;
    guard_bad = 1'b0;
    pos = -1;
    prev_m = 1'b0;
    prev_l = 4'h0;
  end
  // Sample mid-bit, well away from the launching edge
  always @(negedge ref_clk) begin
    if (pixel_frame_marker === 1'b1 && !prev_m) begin
      pos = 0;
      mlen = 4'h0;
      if (prev_l !== 4'h0) guard_bad = 1'b1;
    end
    if (pos >= 0) begin
      a1 = {a1[12:0], serial_data_lane[0]};
      b1 = {b1[12:0], serial_data_lane[1]};
      a2 = {a2[12:0], serial_data_lane[2]};
      b2 = {b2[12:0], serial_data_lane[3]};
      if (pixel_frame_marker) mlen = mlen + 4'h1;
      if (pos == (quad ? 6 : 13)) begin
        rx_ch1 = quad ? {a1[6:0], b1[6:0]} : a1;
        rx_ch2 = quad ? {a2[6:0], b2[6:0]} : b1;
        rx_mlen = mlen;
        rx_cnt++;
        pos = -1;
      end else pos++;
    end
    prev_m = pixel_frame_marker === 1'b1;
    prev_l = serial_data_lane;
  end
endmodule
`default_nettype wire

//--- spotp_top_test.sv
// Self-checking bench for the serial pixel output block
`default_nettype none
module spotp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spotp_pkg::*;
  localparam logic [13:0] C1 = 14'h2d3c;
  localparam logic [13:0] C2 = 14'h0961;
  localparam logic [13:0] VAL = 14'h2c5a;
  logic ref_clk, reset, pixel_clk, clamp_line_pulse, reg_write, pix_run;
  logic quad, pixel_ready, marker, fwd_clk, guard_bad;
  logic [13:0] conv_ch1, conv_ch2, rx_ch1, rx_ch2;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, amp_trim, conv_trim;
  logic [3:0] lanes, rx_mlen;
  spotp_power_s power_down;
  int rx_cnt, n_mismatch, comparisons;
  spotp_top spotp_top_inst (
    .ref_clk(ref_clk), .reset(reset), .pixel_clk(pixel_clk),
    .clamp_line_pulse(clamp_line_pulse), .conv_ch1(conv_ch1),
    .conv_ch2(conv_ch2), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_rdata(reg_rdata),
    .serial_data_lane(lanes), .pixel_frame_marker(marker),
    .forwarded_bit_clock(fwd_clk), .pixel_ready(pixel_ready),
    .power_down(power_down), .amp_trim(amp_trim), .conv_trim(conv_trim));
  spotp_rx_model spotp_rx_model_inst (
    .ref_clk(ref_clk), .serial_data_lane(lanes),
    .pixel_frame_marker(marker), .quad(quad), .rx_ch1(rx_ch1),
    .rx_ch2(rx_ch2), .rx_mlen(rx_mlen), .rx_cnt(rx_cnt),
    .guard_bad(guard_bad));
  // Bit clock, 25 ns
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Pixel clock at 200 ns, parked low while stopped
  initial begin
    pixel_clk = 1'b0;
    forever begin
      repeat (4) @(negedge ref_clk);
      pixel_clk = pix_run ? ~pixel_clk : 1'b0;
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    chk(16'(reg_rdata), 16'(e));
  endtask
  // Bounded wait for n more captured words; a hang ends the run
  task automatic wait_frames(input int n);
    int s, i;
    s = rx_cnt;
    for (i = 0; i < 600 * n && rx_cnt < s + n; i++) @(negedge ref_clk);
    if (rx_cnt < s + n) begin
      n_mismatch++;
      $display("Error at %0t: no frame arrived", $time);
      summarize();
    end
  endtask
  // Tally pattern words against zero and the fixed value
  task automatic count(input int n, output int nv, output int nx);
    int i;
    nv = 0;
    nx = 0;
    for (i = 0; i < n; i++) begin
      wait_frames(1);
      if (i == 2) clamp_line_pulse = 1'b0;
      if (rx_ch1 === VAL && rx_ch2 === VAL) nv++;
      else if (rx_ch1 !== 14'h0 || rx_ch2 !== 14'h0) nx++;
    end
  endtask
  task automatic t_regs();
    logic [5:0] a [5];
    int i;
    a = '{REG_PWR_DOWN, REG_AMP_TRIM, REG_CONV_TRIM, REG_PAT_CTRL,
          REG_TEST_SCAN};
    for (i = 0; i < 5; i++) rd_chk(a[i], 8'h00);
    wr(REG_AMP_TRIM, 8'h09);
    wr(REG_CONV_TRIM, 8'h08);
    wr(6'h3f, 8'hff);
    rd_chk(REG_AMP_TRIM, 8'h09);
    chk(16'(conv_trim), 16'h08);
    rd_chk(6'h3f, 8'h00);
    wr(REG_PWR_DOWN, 8'h38);
    chk(16'(power_down), 16'h2a);
    wr(REG_PWR_DOWN, 8'hb8);
    chk(16'(power_down), 16'h7f);
    wr(REG_PWR_DOWN, 8'h00);
    $display("t_regs done");
  endtask
  // Dual lane: pixels outpace frames, so the buffer fills and refuses
  task automatic t_dual();
    int i, full, hi;
    full = 0;
    hi = 0;
    wait_frames(3);
    chk(16'(rx_ch1), 16'(C1));
    chk(16'(rx_ch2), 16'(C2));
    chk(16'(rx_mlen), 16'h6);
    for (i = 0; i < 200; i++) begin
      @(negedge ref_clk);
      if (pixel_ready === 1'b0) full++;
      if (lanes[3:2] !== 2'b00) hi++;
    end
    chk(16'(hi), 16'h0);
    chk(16'(full > 0), 16'h1);
    $display("t_dual done");
  endtask
  // Quad lane; stopping pixels first drains the buffer to empty
  task automatic t_quad(input logic double_samp);
    int i, hi;
    logic [3:0] m0;
    hi = 0;
    quad = 1'b1;
    pix_run = 1'b0;
    wr(REG_OUT_FMT, {6'h00, double_samp, 1'b1});
    for (i = 0; i < 120; i++) begin
      @(negedge ref_clk);
      if (i > 100 && marker !== 1'b0) hi++;
    end
    chk(16'(hi), 16'h0);
    chk(16'(pixel_ready), 16'h1);
    pix_run = 1'b1;
    wait_frames(3);
    chk(16'(rx_ch1), 16'(C1));
    chk(16'(rx_ch2), 16'(C2));
    m0 = rx_mlen;
    wait_frames(1);
    if (double_samp) chk(16'(m0 + rx_mlen), 16'h5);
    else chk(16'(rx_mlen), 16'h3);
    chk(16'(guard_bad), 16'h0);
    $display("t_quad done");
  endtask
  task automatic t_pattern();
    int nv, nx;
    wr(REG_OUT_FMT, 8'h01);
    wr(REG_TEST_SCAN, 8'h02);
    wr(REG_PAT_START, 8'h02);
    wr(REG_PAT_WIDTH, 8'h03);
    wr(REG_PAT_VAL_HI, 8'h2c);
    wr(REG_PAT_VAL_LO, 8'h5a);
    wr(REG_PAT_CTRL, 8'h01);
    wait_frames(5);
    chk(16'(rx_ch1), 16'h0);
    clamp_line_pulse = 1'b1;
    count(12, nv, nx);
    chk(16'(nv), 16'h3);
    chk(16'(nx), 16'h0);
    wr(REG_PAT_CTRL, 8'h00);
    wr(REG_PAT_CTRL, 8'h61);
    wait_frames(5);
    count(10, nv, nx);
    chk(16'(nv), 16'h6);
    chk(16'(nx), 16'h0);
    wr(REG_PAT_CTRL, 8'h00);
    wr(REG_TEST_SCAN, 8'h00);
    wait_frames(3);
    chk(16'(rx_ch1), 16'(C1));
    $display("t_pattern done");
  endtask
  initial begin
    reset = 1'b1;
    pix_run = 1'b1;
    quad = 1'b0;
    clamp_line_pulse = 1'b0;
    reg_write = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    conv_ch1 = C1;
    conv_ch2 = C2;
    n_mismatch = 0;
    comparisons = 0;
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    t_regs();
    t_dual();
    t_quad(1'b0);
    t_quad(1'b1);
    t_pattern();
    summarize();
  end
endmodule
`default_nettype wire
